// ===== src/uvc_defs.svh
// offsets, field positions, reset values and timing counts of the vendor control registers
`ifndef UVC_DEFS_SVH
`define UVC_DEFS_SVH
`define UVC_ADDR_HEADSET      6'h33
`define UVC_ADDR_ID_WRITE     6'h36
`define UVC_ADDR_ID_SET       6'h37
`define UVC_ADDR_ID_CLEAR     6'h38
`define UVC_ADDR_IO_WRITE     6'h39
`define UVC_ADDR_IO_SET       6'h3A
`define UVC_ADDR_IO_CLEAR     6'h3B
`define UVC_ADDR_CARKIT_STAT  6'h1F
`define UVC_ADDR_CARKIT_LATCH 6'h21
`define UVC_ADDR_VENDOR_LO    6'h30
`define UVC_ADDR_VENDOR_HI    6'h3F
`define UVC_HEADSET_KEY       4'hA
`define UVC_HEADSET_RESET     4'h0
`define UVC_ID_CODE_LSB       0
`define UVC_ID_DONE_BIT       3
`define UVC_ID_GO_BIT         4
`define UVC_ID_MUST_ZERO_BIT  5
`define UVC_ID_IRQ_EN_BIT     6
`define UVC_ID_RW_MASK        8'h70
`define UVC_ID_RESET          8'h00
`define UVC_IO_SWAP_BIT       1
`define UVC_IO_UART_REG_LSB   2
`define UVC_IO_PU_POS_BIT     4
`define UVC_IO_PU_NEG_BIT     5
`define UVC_IO_USB_REG_LSB    6
`define UVC_IO_RW_MASK        8'hFE
`define UVC_IO_RESET          8'h04
`define UVC_LATCH_ID_BIT      3
`define UVC_MEASURE_NS        282000
`define UVC_CLK_NS            20
`define UVC_MEASURE_CYCLES    ((`UVC_MEASURE_NS + `UVC_CLK_NS - 1) / `UVC_CLK_NS)
`endif

// ===== src/uvc_pkg.sv
// types shared by the vendor control register block
package uvc_pkg;
    typedef enum logic [1:0] {
        UVC_MODE_SYNC  = 2'b00,
        UVC_MODE_LOWPW = 2'b01,
        UVC_MODE_SER   = 2'b11,
        UVC_MODE_UART  = 2'b10
    } uvc_mode_e;
    typedef enum logic [1:0] {
        UVC_M_IDLE = 2'b00,
        UVC_M_RUN  = 2'b01,
        UVC_M_DONE = 2'b11
    } uvc_meas_e;
    typedef struct packed {
        logic       we;
        logic       re;
        logic [5:0] addr;
        logic [7:0] wdata;
    } uvc_req_s;
    typedef struct packed {
        logic       swap;
        logic       pu_pos;
        logic       pu_neg;
        logic [1:0] reg_sel;
        logic       headset;
    } uvc_ctl_s;
endpackage

// ===== src/uvc_vendor_regs.sv
// vendor register bank: headset key, id resistor measurement, io/power
`timescale 1ns/1ns
`default_nettype none
`include "uvc_defs.svh"

module uvc_vendor_regs
    import uvc_pkg::*;
#(
    parameter int MEASURE_CYCLES = `UVC_MEASURE_CYCLES
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // immediate register access from the ulpi engine
    input  wire uvc_req_s   req,
    output logic [7:0]      rdata,
    output logic            rhit,
    // carkit side
    input  wire logic       carkit_irq_enable,
    // phy state
    input  wire uvc_mode_e  mode,
    input  wire logic       uart_transmit_enable,
    input  wire logic       audio_mode,
    // measurement converter
    input  wire logic [2:0] converter_code,
    // controls to the analog side
    output uvc_ctl_s        ctl,
    output logic            alt_int,
    output logic            speaker_swap
);

    // the run counter is 20 bits wide, so longer runs cannot be served
    if (MEASURE_CYCLES < 1 || MEASURE_CYCLES > 1048575) begin : g_bad_len
        $error("measure cycle count out of range");
    end

    default clocking uvc_dc @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // ****************************************
    // address decode
    // ****************************************
    wire logic in_vendor = req.addr >= `UVC_ADDR_VENDOR_LO
                        && req.addr <= `UVC_ADDR_VENDOR_HI;
    wire logic a_hs   = req.addr == `UVC_ADDR_HEADSET;
    wire logic a_idw  = req.addr == `UVC_ADDR_ID_WRITE;
    wire logic a_ids  = req.addr == `UVC_ADDR_ID_SET;
    wire logic a_idc  = req.addr == `UVC_ADDR_ID_CLEAR;
    wire logic a_iow  = req.addr == `UVC_ADDR_IO_WRITE;
    wire logic a_ios  = req.addr == `UVC_ADDR_IO_SET;
    wire logic a_ioc  = req.addr == `UVC_ADDR_IO_CLEAR;
    wire logic a_id   = a_idw | a_ids | a_idc;
    wire logic a_io   = a_iow | a_ios | a_ioc;
    wire logic a_ckst = req.addr == `UVC_ADDR_CARKIT_STAT;
    wire logic a_ckl  = req.addr == `UVC_ADDR_CARKIT_LATCH;

    // ****************************************
    // storage
    // ****************************************
    logic [3:0]  hs_reg;
    logic [7:0]  id_ctl_reg;
    logic [7:0]  io_reg;
    logic [2:0]  code_reg;
    logic        done_reg;
    logic        latch_reg;
    logic [19:0] cnt_reg;
    uvc_meas_e   st_reg;

    // ****************************************
    // alias write merge
    // ****************************************
    function automatic logic [7:0] merge(input logic [7:0] cur,
                                         input logic [7:0] wd,
                                         input logic [7:0] rw,
                                         input logic       w,
                                         input logic       s,
                                         input logic       c);
        logic [7:0] r;
        r = cur;
        if (w)
            r = wd;
        else if (s)
            r = cur | wd;
        else if (c)
            r = cur & ~wd;
        return (r & rw) | (cur & ~rw);
    endfunction

    wire logic [7:0] id_wr = merge(id_ctl_reg, req.wdata, `UVC_ID_RW_MASK,
                                   req.we & a_idw, req.we & a_ids,
                                   req.we & a_idc);
    wire logic [7:0] io_wr = merge(io_reg, req.wdata, `UVC_IO_RW_MASK,
                                   req.we & a_iow, req.we & a_ios,
                                   req.we & a_ioc);

    // ****************************************
    // measurement sequencer
    // ****************************************
    wire logic go_now   = id_ctl_reg[`UVC_ID_GO_BIT];
    wire logic finish   = st_reg == UVC_M_RUN
                       && cnt_reg == 20'(MEASURE_CYCLES - 1);
    // go set to 1 while no run is going (idle or done) starts a run
    wire logic start    = st_reg != UVC_M_RUN && go_now;
    wire logic rd_id    = req.re & a_id;
    wire logic irq_en   = id_ctl_reg[`UVC_ID_IRQ_EN_BIT]
                        | carkit_irq_enable;
    wire logic done_rise = finish & ~done_reg;
    wire logic [7:0] id_view = {1'b0, id_ctl_reg[6:4], done_reg, code_reg};

    uvc_meas_e st_next;
    assign st_next = start  ? UVC_M_RUN  :
                     finish ? UVC_M_DONE : st_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg  <= UVC_M_IDLE;
            cnt_reg <= 20'h00000;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= (st_reg == UVC_M_RUN && !finish)
                     ? cnt_reg + 20'h00001 : 20'h00000;
        end
    end

    // ****************************************
    // register updates
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hs_reg     <= `UVC_HEADSET_RESET;
            id_ctl_reg <= `UVC_ID_RESET;
            io_reg     <= `UVC_IO_RESET;
            code_reg   <= 3'h0;
            done_reg   <= 1'b0;
            latch_reg  <= 1'b0;
        end else begin
            if (req.we && a_hs)
                hs_reg <= req.wdata[3:0];
            // completion clears go, a write on the same edge still wins
            id_ctl_reg <= (req.we && a_id) ? id_wr
                        : (finish ? (id_ctl_reg & 8'hEF) : id_ctl_reg);
            if (req.we && a_io)
                io_reg <= io_wr;
            if (finish)
                code_reg <= converter_code;
            // set wins over clear on the same edge
            done_reg  <= finish | (done_reg & ~rd_id);
            // carkit status read leaves done alone
            latch_reg <= (done_rise & irq_en)
                       | (latch_reg & ~(req.re & a_ckl));
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    assign rhit  = req.re & (in_vendor | a_ckst | a_ckl);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            rdata <= 8'h00;
        else if (req.re)
            rdata <= a_hs   ? {4'h0, hs_reg}
                   : a_id   ? id_view
                   : a_io   ? {io_reg[7:1], 1'b0}
                   : a_ckst ? {4'h0, done_reg, code_reg}
                   : a_ckl  ? {4'h0, latch_reg, 3'h0}
                   : 8'h00;
    end

    // ****************************************
    // control outputs
    // ****************************************
    wire logic uart = mode == UVC_MODE_UART;
    wire logic [1:0] reg_pick =
        audio_mode ? 2'b00
      : (uart && uart_transmit_enable)
            ? io_reg[`UVC_IO_UART_REG_LSB +: 2]
      : io_reg[`UVC_IO_USB_REG_LSB +: 2];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctl          <= '0;
            alt_int      <= 1'b0;
            speaker_swap <= 1'b0;
        end else begin
            ctl.headset  <= hs_reg == `UVC_HEADSET_KEY;
            ctl.swap     <= io_reg[`UVC_IO_SWAP_BIT];
            ctl.pu_pos   <= io_reg[`UVC_IO_PU_POS_BIT] | uart;
            ctl.pu_neg   <= io_reg[`UVC_IO_PU_NEG_BIT] | uart;
            ctl.reg_sel  <= reg_pick;
            alt_int      <= done_rise & irq_en;
            speaker_swap <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // independent count of run cycles, so the length check does not
    // lean on the sequencer's own counter
    logic [19:0] run_len_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            run_len_reg <= 20'h00000;
        else if (start)
            run_len_reg <= 20'h00000;
        else if (st_reg == UVC_M_RUN)
            run_len_reg <= run_len_reg + 20'h00001;
    end

    sequence run_s;
        st_reg == UVC_M_RUN;
    endsequence

    sequence ended_s;
        st_reg == UVC_M_DONE && done_reg;
    endsequence

    go_start_a: assert property (start |=> run_s)
        else $error("measurement did not start");
    measure_len_a: assert property (
        $fell(st_reg == UVC_M_RUN)
        |-> ended_s ##0 run_len_reg == 20'(MEASURE_CYCLES))
        else $error("measurement length wrong");
    go_clear_a: assert property (
        finish && !(req.we && a_id) |=> !id_ctl_reg[`UVC_ID_GO_BIT])
        else $error("go bit stayed set");
    done_clear_a: assert property (
        rd_id && !finish |=> !done_reg)
        else $error("done not cleared on read");
    done_keep_a: assert property (
        req.re && a_ckst && done_reg |=> done_reg)
        else $error("carkit read cleared done");
    key_enable_a: assert property (
        ##1 ctl.headset == ($past(hs_reg) == `UVC_HEADSET_KEY))
        else $error("headset enable wrong");
    irq_raise_a: assert property (
        finish && !done_reg && irq_en |=> alt_int && latch_reg)
        else $error("interrupt missing");
    irq_quiet_a: assert property (
        !(finish && !done_reg && (id_ctl_reg[`UVC_ID_IRQ_EN_BIT]
                                  || carkit_irq_enable)) |=> !alt_int)
        else $error("interrupt without enabled done rise");
    carkit_en_a: assert property (
        finish && !done_reg && carkit_irq_enable |=> alt_int && latch_reg)
        else $error("carkit enable ignored");
    latch_clear_a: assert property (
        req.re && a_ckl && !finish |=> !latch_reg)
        else $error("latch not cleared on read");
    code_take_a: assert property (
        finish |=> code_reg == $past(converter_code))
        else $error("result code not taken");
    id_alias_a: assert property (
        req.re && a_id |=> rdata == {1'b0, $past(id_ctl_reg[6:4]),
                                     $past(done_reg), $past(code_reg)})
        else $error("id register read wrong");
    io_alias_a: assert property (
        req.re && a_io |=> rdata == {$past(io_reg[7:1]), 1'b0})
        else $error("io register read wrong");
    pullup_uart_a: assert property (
        uart |=> ctl.pu_pos && ctl.pu_neg)
        else $error("uart pullups off");
    pullup_bits_a: assert property (
        !uart |=> ctl.pu_pos == $past(io_reg[`UVC_IO_PU_POS_BIT])
               && ctl.pu_neg == $past(io_reg[`UVC_IO_PU_NEG_BIT]))
        else $error("pullups do not follow their bits");
    swap_follow_a: assert property (
        ##1 ctl.swap == $past(io_reg[`UVC_IO_SWAP_BIT]))
        else $error("swap does not follow its bit");
    speaker_keep_a: assert property (
        audio_mode |=> !speaker_swap)
        else $error("speaker routing swapped");
    audio_reg_a: assert property (
        audio_mode |=> ctl.reg_sel == 2'b00)
        else $error("audio regulator not 3.3V");
    uart_reg_a: assert property (
        !audio_mode && uart && uart_transmit_enable
        |=> ctl.reg_sel == $past(io_reg[`UVC_IO_UART_REG_LSB +: 2]))
        else $error("uart regulator field not used");
    usb_reg_a: assert property (
        !audio_mode && !uart
        |=> ctl.reg_sel == $past(io_reg[`UVC_IO_USB_REG_LSB +: 2]))
        else $error("usb regulator field not used");
    set_alias_a: assert property (
        req.we && a_ios |=> (io_reg & $past(req.wdata) & `UVC_IO_RW_MASK)
                          == ($past(req.wdata) & `UVC_IO_RW_MASK))
        else $error("set alias lost bits");
    clear_alias_a: assert property (
        req.we && a_ioc
        |=> (io_reg & $past(req.wdata) & `UVC_IO_RW_MASK) == 8'h00)
        else $error("clear alias kept bits");

endmodule
`default_nettype wire

// ===== tb/uvc_link.sv
// link-side model that issues immediate register reads and writes
`timescale 1ns/1ns
`default_nettype none
module uvc_link
    import uvc_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // register access
    output var uvc_req_s    req,
    input  wire logic [7:0] rdata
);
    // ********************
    // access tasks
    // ********************
    initial req = '0;
    // one-cycle write; id register bit 5 is never sent as 1
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req.wdata <= (a inside {[6'h36:6'h38]}) ? (d & 8'hDF) : d;
        req.addr  <= a;
        req.we    <= 1'b1;
        @(posedge ref_clk);
        req <= '0;
    endtask
    // data is taken one cycle after the request drops, when it has settled
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req.addr <= a;
        req.re   <= 1'b1;
        @(posedge ref_clk);
        req <= '0;
        @(posedge ref_clk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ===== tb/uvc_vendor_regs_tb.sv
// self-checking bench for the vendor control register bank
`timescale 1ns/1ns
`default_nettype none
module uvc_vendor_regs_tb
    import uvc_pkg::*;
;
    // ********************
    // signals and instances
    // ********************
    localparam int MC = 50;
    typedef struct packed {
        logic       w;
        logic [5:0] wa;
        logic [7:0] wd;
        logic [5:0] ra;
        logic [7:0] ex;
    } uvc_row_s;
    localparam uvc_row_s ROWS [11] = '{
        '{1'b0, 6'h00, 8'h00, 6'h33, 8'h00},
        '{1'b0, 6'h00, 8'h00, 6'h38, 8'h00},
        '{1'b0, 6'h00, 8'h00, 6'h3B, 8'h04},
        '{1'b1, 6'h33, 8'hFF, 6'h33, 8'h0F},
        '{1'b1, 6'h39, 8'hFF, 6'h3A, 8'hFE},
        '{1'b1, 6'h3B, 8'h0C, 6'h39, 8'hF2},
        '{1'b1, 6'h3A, 8'h01, 6'h3B, 8'hF2},
        '{1'b1, 6'h36, 8'hC0, 6'h36, 8'h40},
        '{1'b1, 6'h38, 8'h40, 6'h37, 8'h00},
        '{1'b1, 6'h3C, 8'h55, 6'h3C, 8'h00},
        '{1'b0, 6'h00, 8'h00, 6'h0A, 8'h00}
    };
    localparam uvc_mode_e MS [3] = '{UVC_MODE_SYNC, UVC_MODE_LOWPW,
                                     UVC_MODE_SER};
    logic       ref_clk = 1'b0;
    logic       rstn    = 1'b0;
    logic       cken    = 1'b0;
    logic       utx     = 1'b0;
    logic       aud     = 1'b0;
    logic [2:0] code    = 3'h0;
    uvc_mode_e  mode    = UVC_MODE_SYNC;
    uvc_req_s   req;
    uvc_ctl_s   ctl;
    logic [7:0] rdata;
    logic [7:0] d;
    logic       rhit;
    logic       hit_seen = 1'b0;
    logic       alt_int;
    logic       spk;
    int         miscompares = 0;
    int         checks_done = 0;
    int         n;
    uvc_vendor_regs #(.MEASURE_CYCLES(MC)) uvc_vendor_regs_inst (
        .ref_clk(ref_clk), .rstn(rstn), .req(req), .rdata(rdata),
        .rhit(rhit), .carkit_irq_enable(cken), .mode(mode),
        .uart_transmit_enable(utx), .audio_mode(aud),
        .converter_code(code), .ctl(ctl), .alt_int(alt_int),
        .speaker_swap(spk));
    uvc_link lnk (.ref_clk(ref_clk), .req(req), .rdata(rdata));
    initial forever #10 ref_clk = ~ref_clk;
    // hit only stands while the read request does
    always @(posedge ref_clk)
        if (req.re)
            hit_seen <= rhit;
    // ********************
    // tasks
    // ********************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        logic h;
        h = a >= 6'h30 || a == 6'h1F || a == 6'h21;
        lnk.rd(a, d);
        chk(d, e);
        chk({7'h00, hit_seen}, {7'h00, h});
    endtask
    // controls lag the registers, so give them a few edges
    task automatic ctc(input logic [7:0] e);
        repeat (3) @(posedge ref_clk);
        chk({2'b00, ctl}, e);
    endtask
    task automatic wirq;
        n = 0;
        // looked at mid-cycle, where the one-cycle pulse has settled
        while (alt_int !== 1'b1 && n < 120) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic results;
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        results();
    end
    // ********************
    // sequence
    // ********************
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].w)
                lnk.wr(ROWS[i].wa, ROWS[i].wd);
            rdc(ROWS[i].ra, ROWS[i].ex);
        end
        for (int k = 0; k < 16; k++) begin
            lnk.wr(6'h33, 8'(k));
            ctc(8'h3E | 8'(k == 10));
        end
        lnk.wr(6'h39, 8'hE2);
        foreach (MS[k]) begin
            mode <= MS[k];
            ctc(8'h2E);
        end
        mode <= UVC_MODE_SYNC;
        aud  <= 1'b1;
        ctc(8'h28);
        chk({7'h00, spk}, 8'h00);
        aud <= 1'b0;
        lnk.wr(6'h39, 8'h0A);
        mode <= UVC_MODE_UART;
        utx  <= 1'b1;
        ctc(8'h3C);
        // uart mode is left through the reset pin
        rstn <= 1'b0;
        mode <= UVC_MODE_SYNC;
        utx  <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        ctc(8'h00);
        rdc(6'h39, 8'h04);
        code <= 3'b101;
        lnk.wr(6'h36, 8'h50);
        rdc(6'h36, 8'h50);
        wirq();
        chk(8'(n >= MC - 8 && n <= MC + 4), 8'h01);
        rdc(6'h1F, 8'h0D);
        rdc(6'h21, 8'h08);
        rdc(6'h21, 8'h00);
        rdc(6'h37, 8'h4D);
        rdc(6'h36, 8'h45);
        lnk.wr(6'h38, 8'h40);
        cken <= 1'b1;
        code <= 3'b111;
        lnk.wr(6'h37, 8'h10);
        wirq();
        chk(8'(n <= MC + 4), 8'h01);
        rdc(6'h38, 8'h0F);
        rdc(6'h21, 8'h08);
        cken <= 1'b0;
        lnk.wr(6'h37, 8'h10);
        wirq();
        chk(8'(n == 120), 8'h01);
        rdc(6'h36, 8'h0F);
        rdc(6'h21, 8'h00);
        results();
    end
endmodule
`default_nettype wire
